//--- bce_pkg.sv
// shared constants, types and arithmetic helpers for the byte crc engine
package bce_pkg;

  // ********************************
  // register map (apb byte addresses)
  // ********************************
  localparam int          ADDR_W   = 8;
  localparam logic [7:0]  OFF_CTRL = 8'h00;
  localparam logic [7:0]  OFF_DIN  = 8'h04;
  localparam logic [7:0]  OFF_RES  = 8'h08;
  localparam logic [7:0]  OFF_AUTO = 8'h0c;
  localparam logic [7:0]  OFF_CNT  = 8'h10;
  localparam logic [7:0]  OFF_REV  = 8'h14;
  localparam logic [7:0]  OFF_STAT = 8'h18;

  // ********************************
  // field positions and widths
  // ********************************
  localparam int SEL_BIT    = 4;
  localparam int INIT_BIT   = 3;
  localparam int VAL_BIT    = 2;
  localparam int PTR_W      = 2;
  localparam int AUTO_FLASH_ENABLE_BIT = 7;
  localparam int PAGE_W     = 7;
  localparam int CNT_W      = 8;
  localparam int SECT_SHIFT = 9;
  localparam int FLASH_AW   = PAGE_W + SECT_SHIFT;
  localparam int LEFT_W     = CNT_W + SECT_SHIFT;

  // ********************************
  // reset values and constants
  // ********************************
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [31:0] RES_ZERO    = 32'h00000000;
  localparam logic [31:0] RES_ONES    = 32'hffffffff;
  localparam logic [15:0] POLY16      = 16'h1021;
  localparam logic [31:0] POLY32_REFL = 32'hedb88320;

  typedef enum logic {BCE_IDLE, BCE_FETCH} bce_walk_e;

  function automatic logic [7:0] bitRev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = b[7-i];
    return r;
  endfunction : bitRev8

endpackage : bce_pkg

//--- bce_byte_update.sv
// one-byte crc update, 16-bit msb-first or 32-bit reflected
`timescale 1ns/1ns
module bce_byte_update
(
  input  wire logic [31:0] crcIn,
  input  wire logic [7:0]  dataByte,
  input  wire logic        sel16,
  output logic      [31:0] crcOut
);

  import bce_pkg::*;

  function automatic logic [15:0] crc16Step(input logic [15:0] c,
                                            input logic [7:0]  b);
    logic [15:0] acc;
    acc = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      acc = acc[15] ? ({acc[14:0], 1'b0} ^ POLY16) : {acc[14:0], 1'b0};
    return acc;
  endfunction : crc16Step

  function automatic logic [31:0] crc32Step(input logic [31:0] c,
                                            input logic [7:0]  b);
    logic [31:0] acc;
    acc = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
      acc = acc[0] ? ({1'b0, acc[31:1]} ^ POLY32_REFL)
                   : {1'b0, acc[31:1]};
    return acc;
  endfunction : crc32Step

  // upper half is left alone in 16-bit operation
  always_comb
  begin
    if (sel16)
      crcOut = {crcIn[31:16], crc16Step(crcIn[15:0], dataByte)};
    else
      crcOut = crc32Step(crcIn, dataByte);
  end

endmodule : bce_byte_update

//--- bce_flash_walk.sv
// sequential flash reader that feeds whole sectors to the crc
`timescale 1ns/1ns
module bce_flash_walk
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         start,
  input  wire logic [bce_pkg::PAGE_W-1:0]   startPage,
  input  wire logic [bce_pkg::CNT_W-1:0]    sectorCount,
  input  wire logic                         flashAck,
  input  wire logic [7:0]                   flashRdata,
  output logic                              flashRd,
  output logic      [bce_pkg::FLASH_AW-1:0] flashAddr,
  output logic                              byteValid,
  output logic      [7:0]                   byteData,
  output logic                              busy
);

  import bce_pkg::*;

  bce_walk_e          state_q;
  logic [LEFT_W-1:0]  left_q;

  assign flashRd   = (state_q == BCE_FETCH);
  assign busy      = (state_q == BCE_FETCH);
  assign byteValid = flashRd & flashAck;
  assign byteData  = flashRdata;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= BCE_IDLE;
      left_q    <= '0;
      flashAddr <= '0;
    end
    else
    begin
      case (state_q)
        BCE_IDLE:
        begin
          // a zero sector count finishes at once
          if (start && sectorCount != '0)
          begin
            state_q   <= BCE_FETCH;
            left_q    <= {sectorCount, {SECT_SHIFT{1'b0}}};
            flashAddr <= {startPage, {SECT_SHIFT{1'b0}}};
          end
        end
        BCE_FETCH:
        begin
          if (flashAck)
          begin
            flashAddr <= flashAddr + 1'b1;
            left_q    <= left_q - 1'b1;
            if (left_q == LEFT_W'(1))
              state_q <= BCE_IDLE;
          end
        end
        default: state_q <= BCE_IDLE;
      endcase
    end
  end

endmodule : bce_flash_walk

//--- bce_crc_engine.sv
// byte crc engine top: apb registers, result store and auto flash run
`timescale 1ns/1ns
module bce_crc_engine
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [bce_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic                              flashRd,
  output logic      [bce_pkg::FLASH_AW-1:0] flashAddr,
  input  wire logic                         flashAck,
  input  wire logic [7:0]                   flashRdata,
  output logic                              cpuStall
);

  import bce_pkg::*;

  // ********************************
  // state
  // ********************************
  logic                polySel_q;
  logic                presetSel_q;
  logic [PTR_W-1:0]    ptr_q;
  logic [31:0]         result_q;
  logic [7:0]          din_q;
  logic [7:0]          rev_q;
  logic                auto_flash_enable_q;
  logic [PAGE_W-1:0]   autoPage_q;
  logic [CNT_W-1:0]    sectorCnt_q;
  logic                ready_q;
  logic                slverr_q;
  logic [31:0]         prdata_q;

  logic                access;
  logic                wrDone;
  logic                rdDone;
  logic                ctrlWr;
  logic                dinWr;
  logic                resAcc;
  logic                startAuto;
  logic                busy;
  logic                autoValid;
  logic [7:0]          autoByte;
  logic [7:0]          updByte;
  logic [31:0]         updResult;
  logic [31:0]         rdMux;

  // ********************************
  // helpers
  // ********************************
  // in 16-bit mode only the low pointer bit picks a byte
  function automatic logic [1:0] byteIdx(input logic [PTR_W-1:0] p,
                                         input logic             s16);
    return s16 ? {1'b0, p[0]} : p;
  endfunction : byteIdx

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_CTRL) || (a == OFF_DIN) || (a == OFF_RES) ||
           (a == OFF_AUTO) || (a == OFF_CNT) || (a == OFF_REV) ||
           (a == OFF_STAT);
  endfunction : isMapped

  // ********************************
  // apb handshake
  // ********************************
  // one wait state lets read data come from a flop; held off while busy
  assign access    = psel & penable;
  assign wrDone    = access & ready_q & pwrite;
  assign rdDone    = access & ready_q & ~pwrite;
  assign pready    = ready_q;
  assign pslverr   = ready_q & slverr_q;
  assign prdata    = prdata_q;
  assign ctrlWr    = wrDone & (paddr == OFF_CTRL);
  assign dinWr     = wrDone & (paddr == OFF_DIN);
  assign resAcc    = (wrDone | rdDone) & (paddr == OFF_RES);
  assign startAuto = ctrlWr & auto_flash_enable_q;
  assign cpuStall  = busy;

  always_comb
  begin
    case (paddr)
      OFF_CTRL: rdMux = {27'h0, polySel_q, 1'b0, presetSel_q, ptr_q};
      OFF_DIN:  rdMux = {24'h0, din_q};
      OFF_RES:  rdMux = {24'h0,
                         result_q[{byteIdx(ptr_q, polySel_q), 3'b000} +: 8]};
      OFF_AUTO: rdMux = {24'h0, auto_flash_enable_q, autoPage_q};
      OFF_CNT:  rdMux = {24'h0, sectorCnt_q};
      OFF_REV:  rdMux = {24'h0, rev_q};
      OFF_STAT: rdMux = {31'h0, busy};
      default:  rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (access && !ready_q && !busy)
    begin
      ready_q  <= 1'b1;
      slverr_q <= ~isMapped(paddr);
      prdata_q <= rdMux;
    end
    else
    begin
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
    end
  end

  // ********************************
  // configuration registers
  // ********************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      polySel_q   <= 1'b0;
      presetSel_q <= 1'b0;
      auto_flash_enable_q    <= 1'b0;
      autoPage_q  <= '0;
      sectorCnt_q <= '0;
      din_q       <= RST_BYTE;
      rev_q       <= RST_BYTE;
    end
    else if (wrDone)
    begin
      case (paddr)
        OFF_CTRL:
        begin
          polySel_q   <= pwdata[SEL_BIT];
          presetSel_q <= pwdata[VAL_BIT];
        end
        OFF_DIN:  din_q <= pwdata[7:0];
        OFF_AUTO:
        begin
          auto_flash_enable_q   <= pwdata[AUTO_FLASH_ENABLE_BIT];
          autoPage_q <= pwdata[PAGE_W-1:0];
        end
        OFF_CNT:  sectorCnt_q <= pwdata[CNT_W-1:0];
        OFF_REV:  rev_q <= bitRev8(pwdata[7:0]);
        default:  din_q <= din_q;
      endcase
    end
  end

  // ********************************
  // byte pointer
  // ********************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ptr_q <= '0;
    else if (ctrlWr)
      ptr_q <= pwdata[PTR_W-1:0];
    else if (resAcc)
      ptr_q <= ptr_q + 1'b1;
  end

  // ********************************
  // crc datapath
  // ********************************
  // apb is held off while the walker runs, so the sources never collide
  assign updByte = autoValid ? autoByte : pwdata[7:0];

  bce_byte_update u_update (
    .crcIn    (result_q),
    .dataByte (updByte),
    .sel16    (polySel_q),
    .crcOut   (updResult)
  );

  bce_flash_walk u_walk (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .start       (startAuto),
    .startPage   (autoPage_q),
    .sectorCount (sectorCnt_q),
    .flashAck    (flashAck),
    .flashRdata  (flashRdata),
    .flashRd     (flashRd),
    .flashAddr   (flashAddr),
    .byteValid   (autoValid),
    .byteData    (autoByte),
    .busy        (busy)
  );

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      result_q <= RES_ZERO;
    else if (ctrlWr && pwdata[INIT_BIT])
      result_q <= pwdata[VAL_BIT] ? RES_ONES : RES_ZERO;
    else if (resAcc && pwrite)
      result_q[{byteIdx(ptr_q, polySel_q), 3'b000} +: 8] <= pwdata[7:0];
    else if (dinWr || autoValid)
      result_q <= updResult;
  end

  // ********************************
  // checks
  // ********************************
  logic [LEFT_W-1:0] autoBytes_q;
  logic [LEFT_W-1:0] expBytes_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      autoBytes_q <= '0;
      expBytes_q  <= '0;
    end
    else if (startAuto)
    begin
      autoBytes_q <= '0;
      expBytes_q  <= {sectorCnt_q, {SECT_SHIFT{1'b0}}};
    end
    else if (autoValid)
      autoBytes_q <= autoBytes_q + 1'b1;
  end

  AST_INIT_ONES: assert property (@(posedge clk_sys)
    disable iff (rst)
    ctrlWr && pwdata[INIT_BIT] && pwdata[VAL_BIT] |=> result_q == RES_ONES)
    else $error("init with all-ones preset did not load ones");

  AST_INIT_ZERO: assert property (@(posedge clk_sys)
    disable iff (rst)
    ctrlWr && pwdata[INIT_BIT] && !pwdata[VAL_BIT] |=> result_q == RES_ZERO)
    else $error("init with zero preset did not clear result");

  AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    !(ctrlWr && pwdata[INIT_BIT]) && !(resAcc && pwrite) && !dinWr
    && !autoValid |=> $stable(result_q))
    else $error("result changed without a cause");

  AST_PTR_ADV: assert property (@(posedge clk_sys)
    disable iff (rst)
    resAcc |=> ptr_q == PTR_W'($past(ptr_q) + 1'b1))
    else $error("pointer did not advance after result access");

  AST_16_UPPER: assert property (@(posedge clk_sys)
    disable iff (rst)
    dinWr && polySel_q |=> result_q[31:16] == $past(result_q[31:16]))
    else $error("16-bit update touched upper half");

  AST_ZERO32: assert property (@(posedge clk_sys) disable iff (rst)
    dinWr && !polySel_q && result_q == {24'h0, pwdata[7:0]}
    |=> result_q == RES_ZERO)
    else $error("32-bit byte not folded into lowest result byte");

  AST_STALL: assert property (@(posedge clk_sys) disable iff (rst)
    startAuto && sectorCnt_q != '0 |=> cpuStall && !pready)
    else $error("auto run did not stall the cpu");

  AST_AUTO_LEN: assert property (@(posedge clk_sys)
    disable iff (rst)
    $fell(busy) |-> autoBytes_q == expBytes_q)
    else $error("auto run processed wrong number of bytes");

  AST_RD16: assert property (@(posedge clk_sys) disable iff (rst)
    rdDone && paddr == OFF_RES && polySel_q
    |-> prdata[7:0] == (ptr_q[0] ? result_q[15:8] : result_q[7:0]))
    else $error("16-bit result byte read from wrong lane");

  AST_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
    psel && !penable |=> !pready)
    else $error("ready came without the wait state");

endmodule : bce_crc_engine

//--- bce_flash_model.sv
// flash memory stand-in that answers the byte fetches of an auto run
`timescale 1ns/1ns
module bce_flash_model
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         flashRd,
  input  wire logic [bce_pkg::FLASH_AW-1:0] flashAddr,
  input  wire logic                         slow,
  output logic                              flashAck,
  output logic      [7:0]                   flashRdata
);
  import bce_pkg::*;

  logic waitQ;

  // when slow, every byte costs one extra cycle so fetch stalls are seen
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      waitQ <= 1'b0;
    else
      waitQ <= flashRd & slow & ~waitQ;

  assign flashAck = flashRd & ~(slow & ~waitQ);

  // outside an ack the data lines show junk, the inverted low address byte, which equals the real byte when flashAddr[15:8] is ff
  assign flashRdata = flashAck ? (flashAddr[7:0] ^ flashAddr[15:8])
                               : ~flashAddr[7:0];
endmodule : bce_flash_model

//--- bce_crc_engine_bench.sv
// self-checking bench for the byte crc engine, driven over apb
`timescale 1ns/1ns
`define CHK(n, e, g) checkVal(n, e, g)
module bce_crc_engine_bench;
  import bce_pkg::*;

  logic                clk_sys = 1'b0;
  logic                rst     = 1'b1;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [7:0]          paddr   = 8'h00;
  logic [31:0]         pwdata  = 32'h0;
  logic                slow    = 1'b0;
  logic [31:0]         prdata, r, v, e;
  logic                pready, pslverr, flashRd, flashAck, cpuStall;
  logic                lastErr, s;
  logic [FLASH_AW-1:0] flashAddr;
  logic [7:0]          flashRdata;
  int                  errorCnt = 0;
  int                  checks   = 0;
  int                  cyc      = 0;
  int                  nAck     = 0;
  logic [39:0] vec [3] = '{40'h63, 40'haabbcc, 40'h0000aabbcc};
  int          len [3] = '{1, 3, 5};
  logic [15:0] e16 [3] = '{16'hbd35, 16'h6cf6, 16'hb166};
  logic [31:0] e32 [3] = '{32'hf9462090, 32'h41b207b3, 32'h78d129bc};

  always #20 clk_sys = ~clk_sys;

  bce_crc_engine dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flashRd(flashRd),
    .flashAddr(flashAddr), .flashAck(flashAck),
    .flashRdata(flashRdata), .cpuStall(cpuStall)
  );

  bce_flash_model flash (
    .clk_sys(clk_sys), .rst(rst), .flashRd(flashRd),
    .flashAddr(flashAddr), .slow(slow), .flashAck(flashAck),
    .flashRdata(flashRdata)
  );

  // ************************************
  // helpers
  // ************************************
  function automatic logic [31:0] upd(input logic [31:0] c,
                                      input logic [7:0] b, input logic h);
    upd = c;
    if (h)
      upd[15:8] = upd[15:8] ^ b;
    else
      upd[7:0] = upd[7:0] ^ b;
    for (int i = 0; i < 8; i++)
      if (h)
        upd[15:0] = {upd[14:0], 1'b0} ^ (upd[15] ? 16'h1021 : 16'h0);
      else
        upd = (upd >> 1) ^ (upd[0] ? 32'hedb88320 : 32'h0);
  endfunction : upd

  task automatic checkVal(input string n, input logic [31:0] ex, got);
    checks++;
    if (got !== ex)
    begin
      errorCnt++;
      $display("CHECK FAILED %s exp %h got %h", n, ex, got);
    end
  endtask : checkVal

  task automatic stopTest();
    if (errorCnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stopTest

  // request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    q       = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask : rd

  // four reads through the byte pointer, lowest byte first
  task automatic getRes(output logic [31:0] w);
    logic [31:0] q;
    for (int k = 0; k < 4; k++)
    begin
      rd(OFF_RES, q);
      w[8*k+:8] = q[7:0];
    end
  endtask : getRes

  always @(posedge clk_sys)
  begin
    cyc++;
    if (flashRd === 1'b1 && flashAck === 1'b1)
      nAck++;
    if (cyc == 10000)
    begin
      errorCnt++;
      stopTest();
    end
  end

  // ************************************
  // tests
  // ************************************
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(OFF_CTRL, r);
    `CHK("ctrl reset", 32'h0, r);
    rd(OFF_AUTO, r);
    `CHK("auto reset", 32'h0, r);
    getRes(v);
    `CHK("result reset", 32'h0, v);
    for (int m = 0; m < 6; m++)
    begin
      s = (m < 3);
      wr(OFF_CTRL, {27'h0, s, 4'b1100});
      for (int i = len[m%3] - 1; i >= 0; i--)
        wr(OFF_DIN, {24'h0, vec[m%3][8*i+:8]});
      getRes(v);
      e = s ? {2{e16[m%3]}} : e32[m%3];
      `CHK("crc", e, v);
    end
    for (int m = 0; m < 2; m++)
    begin
      s = m[0];
      wr(OFF_CTRL, {27'h0, s, 4'b1000});
      getRes(v);
      `CHK("zero preset", 32'h0, v);
      // a zero byte into a zero result must leave it zero
      wr(OFF_DIN, 32'h0);
      wr(OFF_DIN, 32'h63);
      e = upd(32'h0, 8'h63, s);
      getRes(v);
      `CHK("zero crc", s ? {2{e[15:0]}} : e, v);
    end
    wr(OFF_CTRL, 32'h0);
    for (int k = 1; k < 5; k++)
      wr(OFF_RES, 32'h11 * k);
    getRes(v);
    `CHK("overwrite", 32'h44332211, v);
    wr(OFF_DIN, 32'h63);
    getRes(v);
    `CHK("fold", upd(32'h44332211, 8'h63, 1'b0), v);
    wr(OFF_REV, 32'hc4);
    rd(OFF_REV, r);
    `CHK("bit reverse", 32'h23, r);
    rd(8'h1c, r);
    `CHK("unmapped", 1'b1, lastErr);
    `CHK("unmapped data", 32'h0, r);
    wr(OFF_CTRL, 32'h0c);
    wr(OFF_AUTO, 32'h82);
    wr(OFF_CNT, 32'h1);
    slow <= 1'b1;
    wr(OFF_CTRL, 32'h0);
    `CHK("stall", 1'b1, cpuStall);
    `CHK("first addr", 32'h400, flashAddr);
    rd(OFF_STAT, r);
    `CHK("idle after run", 32'h0, r);
    `CHK("bytes", 512, nAck);
    // a zero sector count must not start a run
    wr(OFF_CNT, 32'h0);
    wr(OFF_CTRL, 32'h0);
    `CHK("zero count", 32'h0, cpuStall);
    wr(OFF_AUTO, 32'h0);
    e = 32'hffffffff;
    for (int a = 1024; a < 1536; a++)
      e = upd(e, a[7:0] ^ a[15:8], 1'b0);
    getRes(v);
    `CHK("auto crc", e, v);
    stopTest();
  end
endmodule : bce_crc_engine_bench
